// file: hdl/pscc_slot_regs.sv
// What this block does
// [R01] bit 6 reports hot-plug capable; lockable, resets zero
// [R02] slot-implemented clear makes every capability field read zero, ignore writes
// [R03] eight-bit writable power limit value in bits 14:7
// [R04] power limit message on capability write and on link up
// [R05] two-bit power scale in bits 16:15, decodes 1.0 down to 0.001
// [R06] lockable bit 17 reports interlock fitted, resets zero
// [R07] bit 18 hardwired zero; command completion always notified
// [R08] software programs slot number in bits 31:19, zero on board
// [R09] control fields read zero, unwritable without matching capability
// [R10] bit 0 enables button-pressed events
// [R11] bit 1 enables power fault events
// [R12] bit 2 enables latch sensor change events
// [R13] bit 3 enables presence change events
// [R14] bit 4 enables command-completed interrupt
// [R15] bit 5 is the master hot-plug interrupt enable
// [R16] attention led bits 7:6, reset 3, 1 on 2 blink 3 off
// [R17] indicator field reads zero without its present bit
// [R18] power led bits 9:8, reset 1, same encoding
// [R19] on upstream port power led writes drive nothing
// [R20] bit 10 slot power, 0 on 1 off, resets zero
// [R21] capability bit 4 says power indicator is present
// [R22] write-one-to-clear command-completed flag set on command finish
// [R23] interrupt only when flag, its enable and master enable are set
//
// Purpose: slot capability and slot control registers of one switch port
// Assumes: AXI4-Lite slave, one write and one read in flight
// Notes: event flags live in an extra word with write-one-to-clear bits
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "pscc_defs.svh"
module pscc_slot_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire logic upstream_port,
    input wire logic dl_up,
    input wire logic [`PSCC_EVT_WIDTH-1:0] slot_event,
    input wire logic msg_ack,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] attention_led,
    output logic [1:0] power_led,
    output logic slot_power_off,
    output logic hotplug_irq,
    output logic msg_req,
    output logic [7:0] msg_value,
    output logic [1:0] msg_scale
);
    // ****************************************
    // state
    // ****************************************
    logic [31:0] port_cap_q;
    logic [31:0] cap_q;
    logic [5:0] en_q;
    pscc_pkg::pscc_led_type attention_led_ctrl_q;
    pscc_pkg::pscc_led_type power_led_ctrl_q;
    logic slot_power_ctrl_q;
    logic [`PSCC_EVT_WIDTH-1:0] evt_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    logic [11:0] araddr_q;
    pscc_pkg::pscc_rd_type rd_q;
    logic slot_impl;
    logic [31:0] cap_rd;
    logic [15:0] ctl_rd;
    logic wr_go;
    logic wr_cap;
    logic wr_cap_q;
    logic wr_ctl;
    logic wr_evt;
    logic wr_port;
    logic [31:0] wmask;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    function automatic logic [9:0] word_of(input logic [11:0] a);
        word_of = a[11:2];
    endfunction : word_of

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wmask = strb_mask(wstrb_q);
    assign wr_cap = wr_go && word_of(awaddr_q) == word_of(`PSCC_OFF_SLOT_CAP);
    assign wr_ctl = wr_go && word_of(awaddr_q) == word_of(`PSCC_OFF_SLOT_CTL);
    assign wr_evt = wr_go && word_of(awaddr_q) == word_of(`PSCC_OFF_EVENT);
    assign wr_port = wr_go && word_of(awaddr_q) == word_of(`PSCC_OFF_PORT_CAP);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_cap || wr_ctl || wr_evt || wr_port) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // capability registers
    // ****************************************
    assign slot_impl = port_cap_q[`PSCC_PORT_SLOT_BIT];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            port_cap_q <= 32'h00000000;
        end else if (wr_port) begin
            port_cap_q <= merge(port_cap_q, wdata_q, wmask);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cap_q <= 32'h00000000; // [R01] [R06]
        end else if (wr_cap && slot_impl) begin // [R02]
            cap_q <= merge(cap_q, wdata_q, wmask) & ~(32'h1 << `PSCC_CAP_NO_COMPLETION_SUPPORT); // [R03] [R07]
        end
    end

    always_comb begin
        cap_rd = slot_impl ? cap_q : 32'h00000000; // [R02] [R08]
        cap_rd[`PSCC_CAP_NO_COMPLETION_SUPPORT] = 1'b0; // [R07]
    end

    // message goes out once the written value stands in the register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_cap_q <= 1'b0;
        end else begin
            wr_cap_q <= wr_cap;
        end
    end

    pscc_pwr_msg u_pwr_msg (
        .mclk(mclk),
        .reset(reset),
        .cap_write(wr_cap_q), // [R04]
        .dl_up(dl_up),
        .msg_ack(msg_ack),
        .value(cap_rd[`PSCC_CAP_PLV_HI:`PSCC_CAP_PLV_LO]),
        .scale(pscc_pkg::pscc_scale_type'(cap_rd[`PSCC_CAP_PLS_HI:`PSCC_CAP_PLS_LO])), // [R05]
        .msg_req(msg_req),
        .msg_value(msg_value),
        .msg_scale(msg_scale)
    );

    // ****************************************
    // slot control
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            en_q <= 6'h00;
            attention_led_ctrl_q <= pscc_pkg::pscc_led_type'(`PSCC_ATTN_RESET); // [R16]
            power_led_ctrl_q <= pscc_pkg::pscc_led_type'(`PSCC_PLED_RESET); // [R18]
            slot_power_ctrl_q <= `PSCC_PWR_RESET; // [R20]
        end else if (wr_ctl && cap_rd[`PSCC_CAP_HPC]) begin // [R09]
            if (wstrb_q[0]) begin
                en_q <= wdata_q[`PSCC_CTL_HOTPLUG_IRQ_EN:`PSCC_CTL_BTN]; // [R10] [R11] [R12] [R13] [R14] [R15]
                if (cap_rd[`PSCC_CAP_ATTN_LED]) begin // [R17]
                    attention_led_ctrl_q <= pscc_pkg::pscc_led_type'(
                        wdata_q[`PSCC_CTL_ATTN_HI:`PSCC_CTL_ATTN_LO]); // [R16]
                end
            end
            if (wstrb_q[1] && cap_rd[`PSCC_CAP_PWR_LED]) begin // [R21]
                power_led_ctrl_q <= pscc_pkg::pscc_led_type'(
                    wdata_q[`PSCC_CTL_PLED_HI:`PSCC_CTL_PLED_LO]); // [R18]
            end
            if (wstrb_q[1]) begin
                slot_power_ctrl_q <= wdata_q[`PSCC_CTL_PWR]; // [R20]
            end
        end
    end

    always_comb begin
        ctl_rd = 16'h0000;
        if (cap_rd[`PSCC_CAP_HPC]) begin // [R09]
            ctl_rd[`PSCC_CTL_HOTPLUG_IRQ_EN:`PSCC_CTL_BTN] = en_q;
            ctl_rd[`PSCC_CTL_ATTN_HI:`PSCC_CTL_ATTN_LO] =
                cap_rd[`PSCC_CAP_ATTN_LED] ? attention_led_ctrl_q : 2'h0; // [R17]
            ctl_rd[`PSCC_CTL_PLED_HI:`PSCC_CTL_PLED_LO] =
                cap_rd[`PSCC_CAP_PWR_LED] ? power_led_ctrl_q : 2'h0; // [R17]
            ctl_rd[`PSCC_CTL_PWR] = slot_power_ctrl_q;
        end
    end

    // ****************************************
    // event flags, interrupt and led and power outputs
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            evt_q <= '0;
        end else begin
            // set wins over a same-cycle clear
            evt_q <= (evt_q & ~(wr_evt && wstrb_q[0] ? wdata_q[`PSCC_EVT_WIDTH-1:0] : '0))
                | slot_event; // [R22]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hotplug_irq <= 1'b0;
            attention_led <= 2'h0;
            power_led <= 2'h0;
            slot_power_off <= 1'b0;
        end else begin
            hotplug_irq <= ctl_rd[`PSCC_CTL_HOTPLUG_IRQ_EN]
                && |(evt_q & ctl_rd[`PSCC_CTL_CC:`PSCC_CTL_BTN]); // [R23] [R15]
            attention_led <= ctl_rd[`PSCC_CTL_ATTN_HI:`PSCC_CTL_ATTN_LO];
            power_led <= upstream_port ? 2'h0 : ctl_rd[`PSCC_CTL_PLED_HI:`PSCC_CTL_PLED_LO]; // [R19]
            slot_power_off <= ctl_rd[`PSCC_CTL_PWR]; // [R20]
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_q <= pscc_pkg::PSCC_RD_IDLE;
            araddr_q <= 12'h000;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            case (rd_q)
                pscc_pkg::PSCC_RD_IDLE: begin
                    s_axi_arready <= 1'b1;
                    if (s_axi_arvalid && s_axi_arready) begin
                        araddr_q <= s_axi_araddr;
                        s_axi_arready <= 1'b0;
                        rd_q <= pscc_pkg::PSCC_RD_WAIT;
                    end
                end
                pscc_pkg::PSCC_RD_WAIT: begin
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp <= 2'h0;
                    rd_q <= pscc_pkg::PSCC_RD_RESP;
                    case (word_of(araddr_q))
                        word_of(`PSCC_OFF_PORT_CAP): s_axi_rdata <= port_cap_q;
                        word_of(`PSCC_OFF_SLOT_CAP): s_axi_rdata <= cap_rd;
                        word_of(`PSCC_OFF_SLOT_CTL): s_axi_rdata <= {16'h0000, ctl_rd};
                        word_of(`PSCC_OFF_EVENT): s_axi_rdata <= {27'h0, evt_q};
                        default: begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= 2'h2;
                        end
                    endcase
                end
                pscc_pkg::PSCC_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_q <= pscc_pkg::PSCC_RD_IDLE;
                    end
                end
                default: rd_q <= pscc_pkg::PSCC_RD_IDLE;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_cap_locked: assert property (@(posedge mclk) disable iff (reset)
        !slot_impl |-> cap_rd == 32'h0) // [R02]
        else $error("capabilities visible without slot");
    a_no_completion_support_zero: assert property (@(posedge mclk) disable iff (reset)
        cap_rd[`PSCC_CAP_NO_COMPLETION_SUPPORT] == 1'b0) // [R07]
        else $error("no-completion bit not zero");
    a_ctl_gated: assert property (@(posedge mclk) disable iff (reset)
        !cap_rd[`PSCC_CAP_HPC] |-> ctl_rd == 16'h0) // [R09]
        else $error("control visible without hot-plug capability");
    a_led_hidden: assert property (@(posedge mclk) disable iff (reset)
        !cap_rd[`PSCC_CAP_ATTN_LED] |=> attention_led == 2'h0) // [R17]
        else $error("attention led shown without present bit");
    a_up_pled: assert property (@(posedge mclk) disable iff (reset)
        upstream_port |=> power_led == 2'h0) // [R19]
        else $error("power led driven on upstream port");
    a_irq_cause: assert property (@(posedge mclk) disable iff (reset)
        hotplug_irq |-> $past(ctl_rd[`PSCC_CTL_HOTPLUG_IRQ_EN])) // [R15] [R23]
        else $error("interrupt without master enable");
    a_irq_raise: assert property (@(posedge mclk) disable iff (reset)
        (ctl_rd[`PSCC_CTL_HOTPLUG_IRQ_EN] && evt_q[`PSCC_EVT_CC] && ctl_rd[`PSCC_CTL_CC])
        |=> hotplug_irq) // [R14]
        else $error("command done interrupt missing");
    a_cc_sticky: assert property (@(posedge mclk) disable iff (reset)
        slot_event[`PSCC_EVT_CC] |=> evt_q[`PSCC_EVT_CC]) // [R22]
        else $error("command completed flag lost");
    a_pwr_follow: assert property (@(posedge mclk) disable iff (reset)
        slot_power_off == $past(ctl_rd[`PSCC_CTL_PWR])) // [R20]
        else $error("power output not following control");
    a_msg_new_value: assert property (@(posedge mclk) disable iff (reset) // [R04]
        (wr_cap && slot_impl) |-> ##2 msg_req && msg_value == cap_rd[`PSCC_CAP_PLV_HI:`PSCC_CAP_PLV_LO])
        else $error("power limit message without the written value");
    c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(hotplug_irq));
    c_cap_wr: cover property (@(posedge mclk) disable iff (reset) wr_cap && slot_impl);
    c_ctl_wr: cover property (@(posedge mclk) disable iff (reset) wr_ctl && cap_rd[`PSCC_CAP_HPC]);
endmodule : pscc_slot_regs

// file: hdl/pscc_defs.svh
// Purpose: offsets, field positions and reset values of the slot register bank
// Assumes: byte addressing on a 32-bit AXI4-Lite bus
// Notes: included by the design modules and the bench; the package does not include it
`ifndef PSCC_DEFS_SVH
`define PSCC_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define PSCC_OFF_PORT_CAP 12'h050
`define PSCC_OFF_SLOT_CAP 12'h054
`define PSCC_OFF_SLOT_CTL 12'h058
`define PSCC_OFF_EVENT 12'h05C
// ****************************************
// slot capabilities fields
// ****************************************
`define PSCC_CAP_ATTN_LED 3
`define PSCC_CAP_PWR_LED 4
`define PSCC_CAP_HPC 6
`define PSCC_CAP_PLV_LO 7
`define PSCC_CAP_PLV_HI 14
`define PSCC_CAP_PLS_LO 15
`define PSCC_CAP_PLS_HI 16
`define PSCC_CAP_EIP 17
`define PSCC_CAP_NO_COMPLETION_SUPPORT 18
`define PSCC_CAP_PSN_LO 19
`define PSCC_CAP_PSN_HI 31
`define PSCC_CAP_LOW_MASK 32'h0000003F
// ****************************************
// slot control fields
// ****************************************
`define PSCC_CTL_BTN 0
`define PSCC_CTL_PF 1
`define PSCC_CTL_LATCH 2
`define PSCC_CTL_PRES 3
`define PSCC_CTL_CC 4
`define PSCC_CTL_HOTPLUG_IRQ_EN 5
`define PSCC_CTL_ATTN_LO 6
`define PSCC_CTL_ATTN_HI 7
`define PSCC_CTL_PLED_LO 8
`define PSCC_CTL_PLED_HI 9
`define PSCC_CTL_PWR 10
`define PSCC_ATTN_RESET 2'h3
`define PSCC_PLED_RESET 2'h1
`define PSCC_PWR_RESET 1'h0
`define PSCC_EVT_WIDTH 5
`define PSCC_EVT_CC 4
`define PSCC_PORT_SLOT_BIT 8
`endif

// file: hdl/pscc_pkg.sv
// Purpose: shared types of the slot register bank
// Assumes: nothing beyond the defs header
// Notes: nothing is imported; use pscc_pkg::name
package pscc_pkg;
    typedef enum logic [1:0] {
        PSCC_LED_RSVD = 2'h0,
        PSCC_LED_ON = 2'h1,
        PSCC_LED_BLINK = 2'h2,
        PSCC_LED_OFF = 2'h3
    } pscc_led_type;
    typedef enum logic [1:0] {
        PSCC_SCALE_1 = 2'h0,
        PSCC_SCALE_P1 = 2'h1,
        PSCC_SCALE_P01 = 2'h2,
        PSCC_SCALE_P001 = 2'h3
    } pscc_scale_type;
    typedef enum logic [1:0] {
        PSCC_RD_IDLE = 2'h0,
        PSCC_RD_WAIT = 2'h1,
        PSCC_RD_RESP = 2'h2
    } pscc_rd_type;
endpackage : pscc_pkg

// file: hdl/pscc_pwr_msg.sv
// Purpose: issues the slot power limit message request
// Assumes: write strobe is a one-cycle pulse
// Notes: request stays up until acknowledged
`include "pscc_defs.svh"
module pscc_pwr_msg (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cap_write,
    input wire logic dl_up,
    input wire logic msg_ack,
    input wire logic [7:0] value,
    input wire pscc_pkg::pscc_scale_type scale,
    output logic msg_req,
    output logic [7:0] msg_value,
    output logic [1:0] msg_scale
);
    logic dl_up_q;
    logic trig;
    assign trig = cap_write | (dl_up & ~dl_up_q);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dl_up_q <= 1'b0;
        end else begin
            dl_up_q <= dl_up;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            msg_req <= 1'b0;
            msg_value <= 8'h00;
            msg_scale <= 2'h0;
        end else if (trig) begin
            msg_req <= 1'b1;
            msg_value <= value;
            msg_scale <= scale;
        end else if (msg_ack) begin
            msg_req <= 1'b0;
        end
    end
    a_msg_on_write: assert property (@(posedge mclk) disable iff (reset)
        cap_write |=> msg_req && msg_value == $past(value)) // [R04]
        else $error("no power limit message after capability write");
    a_msg_on_dlup: assert property (@(posedge mclk) disable iff (reset)
        (dl_up && !dl_up_q) |=> msg_req) // [R04]
        else $error("no power limit message on link up");
    c_link_up: cover property (@(posedge mclk) disable iff (reset) dl_up && !dl_up_q);
endmodule : pscc_pwr_msg

// file: sim/pscc_slot_model.sv
// Purpose: slot side of the port: buttons, sensors and power limit sink
// Assumes: msg_req is a level held until msg_ack
// Notes: ack_delay sets a prompt or slow answer to the power message
module pscc_slot_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic msg_req,
    input wire logic [7:0] msg_value,
    input wire logic [1:0] msg_scale,
    output logic [4:0] slot_event,
    output logic msg_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    int ack_delay;
    int n_msg;
    logic [7:0] got_value;
    logic [1:0] got_scale;
    // ****************************************
    // power limit message sink
    // ****************************************
    initial begin
        slot_event = 5'h00;
        msg_ack = 1'b0;
        ack_delay = 0;
        n_msg = 0;
        forever begin
            @(posedge mclk);
            if (msg_req === 1'b1 && reset === 1'b0) begin
                got_value = msg_value;
                got_scale = msg_scale;
                repeat (ack_delay) @(posedge mclk);
                msg_ack <= 1'b1;
                @(posedge mclk);
                msg_ack <= 1'b0;
                n_msg++;
            end
        end
    end
    // one-cycle event from a slot sensor or button
    task pulse(input int i);
        begin
            @(posedge mclk);
            slot_event[i] <= 1'b1;
            @(posedge mclk);
            slot_event <= 5'h00;
        end
    endtask : pulse
endmodule : pscc_slot_model

// file: sim/pcie_slot_cap_ctrl_regs_bench.sv
// Purpose: self-checking bench of the slot register bank
// Assumes: AXI4-Lite master tasks, slot model on the event and message side
// Notes: ends in summarize
`include "pscc_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (g), (e)); end end
module pcie_slot_cap_ctrl_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] A_PORT = `PSCC_OFF_PORT_CAP;
    localparam logic [11:0] A_CAP = `PSCC_OFF_SLOT_CAP;
    localparam logic [11:0] A_CTL = `PSCC_OFF_SLOT_CTL;
    localparam logic [11:0] A_EVT = `PSCC_OFF_EVENT;
    logic mclk, reset, upstream_port, dl_up, msg_ack, msg_req, hotplug_irq, slot_power_off;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [4:0] slot_event;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, dat;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, attention_led, power_led, msg_scale, rsp;
    logic [7:0] msg_value;
    int n_fail, checked, cycles, n0;
    pscc_slot_regs u_dut (.mclk(mclk), .reset(reset), .upstream_port(upstream_port),
        .dl_up(dl_up), .slot_event(slot_event), .msg_ack(msg_ack),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .attention_led(attention_led),
        .power_led(power_led), .slot_power_off(slot_power_off),
        .hotplug_irq(hotplug_irq), .msg_req(msg_req), .msg_value(msg_value),
        .msg_scale(msg_scale));
    pscc_slot_model u_slot (.mclk(mclk), .reset(reset), .msg_req(msg_req),
        .msg_value(msg_value), .msg_scale(msg_scale), .slot_event(slot_event),
        .msg_ack(msg_ack));
    // ****************************************
    // bus, message, event and summary tasks
    // ****************************************
    task summarize;
        begin
            if (n_fail == 0 && checked > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask : summarize
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ad, wd;
        begin
            @(posedge mclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            ad = 1'b0;
            wd = 1'b0;
            while (!(ad && wd)) begin
                @(posedge mclk);
                if (!ad && awready === 1'b1) begin
                    ad = 1'b1;
                    awvalid <= 1'b0;
                end
                if (!wd && wready === 1'b1) begin
                    wd = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            while (bvalid !== 1'b1) @(posedge mclk);
            `CHK(bresp, er)
            bready <= 1'b0;
        end
    endtask : wr
    task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            @(posedge mclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge mclk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            while (rvalid !== 1'b1) @(posedge mclk);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask : rd
    task rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        begin
            rd(a, d, r);
            `CHK(r, 2'h0)
            `CHK(d, e)
        end
    endtask : rc
    task msg(input logic [7:0] v, input logic [1:0] s);
        int t;
        begin
            t = 0;
            while (u_slot.n_msg == n0 && t < 200) begin
                @(posedge mclk);
                t++;
            end
            `CHK(u_slot.n_msg, n0 + 1)
            `CHK(u_slot.got_value, v)
            `CHK(u_slot.got_scale, s)
        end
    endtask : msg
    task ev(input int i);
        begin
            u_slot.pulse(i);
            repeat (3) @(posedge mclk);
        end
    endtask : ev
    function automatic logic [31:0] capw(input logic [1:0] s, input logic [5:0] lo);
        return {13'h0155, 1'b1, 1'b1, s, 8'hA5, 1'b1, lo};
    endfunction : capw
    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize;
        end
    end
    initial begin
        {reset, upstream_port, dl_up, awvalid, wvalid, bready, arvalid, rready} = 8'hFF;
        {upstream_port, dl_up, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        {n_fail, checked, cycles} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rc(A_CAP, 32'h0);
        rc(A_CTL, 32'h0);
        `CHK(attention_led, 2'h0)
        `CHK(slot_power_off, 1'b0)
        wr(A_CAP, 32'hFFFF_FFFF, 4'hF, 2'h0);
        wr(A_CTL, 32'h0000_07FF, 4'hF, 2'h0);
        rc(A_CAP, 32'h0);
        rc(A_CTL, 32'h0);
        wr(A_PORT, 32'h0000_0100, 4'hF, 2'h0);
        n0 = u_slot.n_msg;
        wr(A_CAP, capw(2'h0, 6'h3F) & 32'hFFFF_FFBF, 4'hF, 2'h0);
        msg(8'hA5, 2'h0);
        wr(A_CTL, 32'h0000_07FF, 4'hF, 2'h0);
        rc(A_CTL, 32'h0);
        for (int s = 0; s < 4; s++) begin
            u_slot.ack_delay = s * 6;
            n0 = u_slot.n_msg;
            wr(A_CAP, capw(s[1:0], 6'h3F), 4'hF, 2'h0);
            msg(8'hA5, s[1:0]);
            rc(A_CAP, capw(s[1:0], 6'h3F) & 32'hFFFB_FFFF);
        end
        rc(A_CTL, 32'h0000_01C0);
        `CHK(attention_led, 2'h3)
        `CHK(power_led, 2'h1)
        wr(A_CTL, 32'h0000_FF80, 4'h1, 2'h0);
        rc(A_CTL, 32'h0000_0180);
        `CHK(attention_led, 2'h2)
        wr(A_CTL, 32'h0000_0740, 4'hF, 2'h0);
        rc(A_CTL, 32'h0000_0740);
        `CHK(power_led, 2'h3)
        `CHK(slot_power_off, 1'b1)
        upstream_port <= 1'b1;
        wr(A_CTL, 32'h0000_0280, 4'hF, 2'h0);
        @(posedge mclk);
        `CHK(power_led, 2'h0)
        `CHK(attention_led, 2'h2)
        upstream_port <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(power_led, 2'h2)
        n0 = u_slot.n_msg;
        wr(A_CAP, capw(2'h3, 6'h27), 4'hF, 2'h0);
        msg(8'hA5, 2'h3);
        rc(A_CTL, 32'h0);
        `CHK(attention_led, 2'h0)
        `CHK(power_led, 2'h0)
        n0 = u_slot.n_msg;
        wr(A_CAP, capw(2'h3, 6'h3F), 4'hF, 2'h0);
        msg(8'hA5, 2'h3);
        for (int i = 0; i < 5; i++) begin
            wr(A_CTL, 32'h0000_03E0 | (32'h1 << i), 4'hF, 2'h0);
            ev(i);
            `CHK(hotplug_irq, 1'b1)
            rc(A_EVT, 32'h1 << i);
            wr(A_EVT, 32'h1 << i, 4'hF, 2'h0);
            rc(A_EVT, 32'h0);
            `CHK(hotplug_irq, 1'b0)
        end
        wr(A_CTL, 32'h0000_03C1, 4'hF, 2'h0);
        ev(0);
        `CHK(hotplug_irq, 1'b0)
        wr(A_CTL, 32'h0000_03E1, 4'hF, 2'h0);
        repeat (2) @(posedge mclk);
        `CHK(hotplug_irq, 1'b1)
        wr(A_CTL, 32'h0000_03E2, 4'hF, 2'h0);
        repeat (2) @(posedge mclk);
        `CHK(hotplug_irq, 1'b0)
        n0 = u_slot.n_msg;
        dl_up <= 1'b1;
        msg(8'hA5, 2'h3);
        rd(12'h100, dat, rsp);
        `CHK(rsp, 2'h2)
        wr(12'h100, 32'h0, 4'hF, 2'h2);
        summarize;
    end
endmodule : pcie_slot_cap_ctrl_regs_bench
